// File: tsp_timer.v
// 8-bit timer/counter with shared prescaler, Avalon-MM register slave
// Operation
// - clock-source bit zero selects timer mode from instruction cycles.
// - timer mode without prescaler adds one per instruction cycle.
// - a count write blocks counting for two cycles, then continues.
// - clock-source bit one counts edges of the counter input pin.
// - edge-select zero counts rising edges, one counts falling edges.
// - assignment bit zero gives divider to timer, one to watchdog.
// - software can neither read nor write the divider count.
// - divider on timer divides by 2 up to 256 by ratio field.
// - count rolling from FF to 00 sets the overflow flag.
// - interrupt request only while enable and overflow flag both set.
// - hardware never clears the flag; software clears it first.
// - timer stops during sleep, so overflow never wakes the cpu.
// - external source is sampled at Q2 and Q4 of each cycle.
// - with prescaler pin is divided first; period over 4Tosc/ratio.
// - counter mode updates count only after the sampling stage.
// - one 8-bit divider serves timer or watchdog, never both.
// - divider on timer is cleared by every count write.
// - divider on watchdog is cleared by the watchdog clear.
// - assignment and ratio may change anytime and act at once.
`timescale 1ns/1ps
`include "tsp_defs.vh"

module tsp_timer (
  mclk,
  rst_n,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  counter_input_pin,
  sleep_mode,
  watchdog_tick,
  watchdog_clear_instruction,
  watchdog_tick_scaled,
  timer_irq,
  port_a_direction
);
  input  wire        mclk;
  input  wire        rst_n;
  input  wire [9:0]  avs_address;
  input  wire        avs_read;
  input  wire        avs_write;
  input  wire [31:0] avs_writedata;
  input  wire [3:0]  avs_byteenable;
  output reg  [31:0] avs_readdata;
  output wire        avs_waitrequest;
  input  wire        counter_input_pin;
  input  wire        sleep_mode;
  input  wire        watchdog_tick;
  input  wire        watchdog_clear_instruction;
  output wire        watchdog_tick_scaled;
  output reg         timer_irq;
  output wire [4:0]  port_a_direction;

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  reg        ack_reg;
  reg  [7:0] timer_count_reg;
  reg  [7:0] timer_count_next;
  reg  [7:0] int_control_reg;
  reg  [7:0] int_control_next;
  reg  [7:0] prescale_cfg_reg;
  reg  [4:0] port_a_dir_reg;
  reg  [1:0] phase_reg;
  reg  [1:0] inhibit_reg;
  reg  [1:0] inhibit_next;
  reg        pin_meta_reg;
  reg        pin_sync_reg;
  reg        pin_prev_reg;
  reg        pend_reg;
  reg        sampled_reg;
  reg  [7:0] read_value;

  wire       req;
  wire       wr_fire;
  wire [7:0] idx;
  wire [7:0] wdata;
  wire       wr_count;
  wire       wr_intctl;
  wire       wr_cfg;
  wire       wr_porta;
  wire       clock_source_select;
  wire       edge_select;
  wire       divider_assignment;
  wire [2:0] divider_ratio_field;
  wire       instr_tick;
  wire       sample_now;
  wire       pin_rise;
  wire       pin_fall;
  wire       ext_edge;
  wire       src_tick;
  wire       div_in;
  wire       div_out;
  wire       div_clear;
  wire [3:0] div_log2;
  wire       timer_pulse;
  wire       inc_pulse;
  wire       inc_en;
  wire       overflow;

  // -------------------------------------------------------------
  // bus slave: one wait cycle, then the answer
  // -------------------------------------------------------------
  function is_idx;
    input [9:0] addr;
    input [7:0] index;
    begin
      is_idx = (addr[1:0] == 2'h0) && (addr[9:2] == index);
    end
  endfunction

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_fire         = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign idx             = avs_address[9:2];
  assign wdata           = avs_writedata[7:0];
  assign wr_count  = wr_fire & is_idx(avs_address, `TSP_IDX_TIMER_COUNT);
  assign wr_intctl = wr_fire & is_idx(avs_address, `TSP_IDX_INT_CONTROL);
  assign wr_cfg    = wr_fire & is_idx(avs_address, `TSP_IDX_PRESCALE_CFG);
  assign wr_porta  = wr_fire & is_idx(avs_address, `TSP_IDX_PORT_A_DIR);

  // divider count has no address at all
  always @* begin
    read_value = 8'h00;
    if (avs_address[1:0] == 2'h0) begin
      case (idx)
        `TSP_IDX_TIMER_COUNT: begin
          read_value = timer_count_reg;
        end
        `TSP_IDX_INT_CONTROL: begin
          read_value = int_control_reg;
        end
        `TSP_IDX_PRESCALE_CFG: begin
          read_value = prescale_cfg_reg;
        end
        `TSP_IDX_PORT_A_DIR: begin
          read_value = {3'h0, port_a_dir_reg};
        end
        default: begin
          read_value = 8'h00;
        end
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        avs_readdata <= {24'h000000, read_value};
      end
    end
  end

  // -------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------
  // new assignment and ratio act on the very next edge
  assign clock_source_select = prescale_cfg_reg[`TSP_CFG_CLOCK_SOURCE];
  assign edge_select         = prescale_cfg_reg[`TSP_CFG_EDGE_SELECT];
  assign divider_assignment  = prescale_cfg_reg[`TSP_CFG_ASSIGNMENT];
  assign divider_ratio_field =
    prescale_cfg_reg[`TSP_CFG_RATIO_MSB:`TSP_CFG_RATIO_LSB];
  assign port_a_direction    = port_a_dir_reg;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_cfg_reg <= `TSP_RST_PRESCALE_CFG;
      port_a_dir_reg   <= `TSP_RST_PORT_A_DIR;
    end else begin
      if (wr_cfg) begin
        prescale_cfg_reg <= wdata;
      end
      if (wr_porta) begin
        port_a_dir_reg <= wdata[`TSP_PORTA_MSB:0];
      end
    end
  end

  // -------------------------------------------------------------
  // phase clocks: Q1..Q4 make one instruction cycle
  // -------------------------------------------------------------
  assign instr_tick = (phase_reg == `TSP_PHASE_Q4);
  assign sample_now = (phase_reg == `TSP_PHASE_Q2) | instr_tick;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // -------------------------------------------------------------
  // counter input pin: synchroniser and edge select
  // -------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= counter_input_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign pin_rise = pin_sync_reg & ~pin_prev_reg;
  assign pin_fall = ~pin_sync_reg & pin_prev_reg;
  assign ext_edge = edge_select ? pin_fall : pin_rise;

  // timer mode counts cycles, counter mode counts pin edges
  // nothing is counted in sleep
  assign src_tick = ~sleep_mode & (clock_source_select ? ext_edge
                                                       : instr_tick);

  // -------------------------------------------------------------
  // shared divider
  // -------------------------------------------------------------
  // one divider, fed by exactly one user
  assign div_in = divider_assignment ? watchdog_tick : src_tick;

  // timer ratios 1:2..1:256, watchdog 1:1..1:128
  assign div_log2 = divider_assignment ? {1'b0, divider_ratio_field}
                                       : {1'b0, divider_ratio_field}
                                         + 4'h1;

  // count write clears it on timer watchdog clear on
  // watchdog
  assign div_clear = divider_assignment ? watchdog_clear_instruction
                                        : wr_count;

  // with the divider on the timer, pin edges are divided before the sampling stage
  tsp_divider u_divider (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .clear    (div_clear),
    .tick_in  (div_in),
    .div_log2 (div_log2),
    .tick_out (div_out)
  );

  assign watchdog_tick_scaled = divider_assignment ? div_out
                                                   : watchdog_tick;
  assign timer_pulse = divider_assignment ? src_tick : div_out;

  // -------------------------------------------------------------
  // sampling stage for the external source
  // -------------------------------------------------------------
  // hold the timer pulse (divider output, or pin edge with divider on watchdog) until the next Q2 or Q4
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg    <= 1'b0;
      sampled_reg <= 1'b0;
    end else begin
      pend_reg    <= (timer_pulse & clock_source_select)
                     | (pend_reg & ~sample_now);
      sampled_reg <= pend_reg & sample_now & ~sleep_mode;
    end
  end

  // counter mode counts only the sampled pulse
  assign inc_pulse = clock_source_select ? sampled_reg : timer_pulse;

  // -------------------------------------------------------------
  // write inhibit
  // -------------------------------------------------------------
  always @* begin
    inhibit_next = inhibit_reg;
    if (wr_count) begin
      inhibit_next = `TSP_WRITE_INHIBIT;
    end else if (instr_tick && (inhibit_reg != 2'h0)) begin
      inhibit_next = inhibit_reg - 2'h1;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      inhibit_reg <= 2'h0;
    end else begin
      inhibit_reg <= inhibit_next;
    end
  end

  // -------------------------------------------------------------
  // count register
  // -------------------------------------------------------------
  // one step per accepted pulse none while inhibited
  // or asleep
  assign inc_en   = inc_pulse & ~sleep_mode & ~wr_count
                    & (inhibit_reg == 2'h0);
  assign overflow = inc_en & (timer_count_reg == `TSP_COUNT_MAX);

  always @* begin
    timer_count_next = timer_count_reg;
    if (wr_count) begin
      timer_count_next = wdata;
    end else if (inc_en) begin
      timer_count_next = timer_count_reg + 8'h01;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count_reg <= `TSP_RST_TIMER_COUNT;
    end else begin
      timer_count_reg <= timer_count_next;
    end
  end

  // -------------------------------------------------------------
  // interrupt control and request
  // -------------------------------------------------------------
  always @* begin
    int_control_next = int_control_reg;
    if (wr_intctl) begin
      int_control_next = wdata;
    end
    // set beats a software clear in the same cycle
    // and only software ever clears it
    if (overflow) begin
      int_control_next[`TSP_INT_OVF_FLAG] = 1'b1;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_control_reg <= `TSP_RST_INT_CONTROL;
      timer_irq       <= 1'b0;
    end else begin
      int_control_reg <= int_control_next;
      timer_irq       <= int_control_next[`TSP_INT_IRQ_ENABLE]
                         & int_control_next[`TSP_INT_OVF_FLAG];
    end
  end

endmodule

// File: tsp_defs.vh
// register map, field positions, reset values and timing counts
`ifndef TSP_DEFS_VH
`define TSP_DEFS_VH

// -------------------------------------------------------------
// register indices (byte address is four times the index)
// -------------------------------------------------------------
`define TSP_IDX_TIMER_COUNT   8'h01
`define TSP_IDX_INT_CONTROL   8'h0B
`define TSP_IDX_PRESCALE_CFG  8'h81
`define TSP_IDX_PORT_A_DIR    8'h85

// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define TSP_CFG_CLOCK_SOURCE  5
`define TSP_CFG_EDGE_SELECT   4
`define TSP_CFG_ASSIGNMENT    3
`define TSP_CFG_RATIO_MSB     2
`define TSP_CFG_RATIO_LSB     0
`define TSP_INT_IRQ_ENABLE    5
`define TSP_INT_OVF_FLAG      2
`define TSP_PORTA_MSB         4

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define TSP_RST_TIMER_COUNT   8'h00
`define TSP_RST_INT_CONTROL   8'h00
`define TSP_RST_PRESCALE_CFG  8'hFF
`define TSP_RST_PORT_A_DIR    5'h1F
`define TSP_COUNT_MAX         8'hFF

// -------------------------------------------------------------
// timing: one mclk is one oscillator period, four make a cycle
// -------------------------------------------------------------
`define TSP_PHASE_Q2          2'h1
`define TSP_PHASE_Q4          2'h3
`define TSP_WRITE_INHIBIT     2'h2

`endif

// File: tsp_divider.v
// shared 8-bit divider: timer prescaler or watchdog postscaler
`timescale 1ns/1ps

module tsp_divider (
  mclk,
  rst_n,
  clear,
  tick_in,
  div_log2,
  tick_out
);
  input  wire       mclk;
  input  wire       rst_n;
  input  wire       clear;
  input  wire       tick_in;
  input  wire [3:0] div_log2;
  output wire       tick_out;

  reg  [7:0] count_reg;
  reg  [7:0] count_next;
  wire [7:0] mask;
  wire [8:0] mask_wide;

  // -------------------------------------------------------------
  // carry detect: one output per 2**div_log2 input ticks
  // -------------------------------------------------------------
  assign mask_wide = (9'h001 << div_log2) - 9'h001;
  assign mask      = mask_wide[7:0];
  assign tick_out  = tick_in & ~clear & ((count_reg & mask) == mask);

  always @* begin
    count_next = count_reg;
    if (clear) begin
      count_next = 8'h00;
    end else if (tick_in) begin
      count_next = count_reg + 8'h01;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// File: tsp_pin_src.sv
// external clock source that drives the counter input pin
`timescale 1ns/1ps
module tsp_pin_src (
  mclk,
  pin
);
  input  wire  mclk;
  output logic pin;
  initial pin = 1'b0;
  // ----
  // pin drive, idles low between bursts
  // ----
  task automatic level(input logic v);
    @(posedge mclk) pin <= v;
  endtask
  // each level held at least two oscillator periods
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge mclk) pin <= 1'b1;
      repeat (hi) @(posedge mclk);
      pin <= 1'b0;
      repeat (lo - 1) @(posedge mclk);
    end
  endtask
endmodule

// File: tsp_timer_properties.sv
// port-level checker for the timer/counter block
`timescale 1ns/1ps
module tsp_timer_properties (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        sleep_mode,
  input wire logic        watchdog_tick,
  input wire logic        watchdog_tick_scaled,
  input wire logic        timer_irq,
  input wire logic [4:0]  port_a_direction
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire req = avs_read | avs_write;
  // ----
  // assertions
  // ----
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("new request not held off");
  a_wait_single: assert property (
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  a_idle_ready: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised without request");
  a_read_upper: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_scaled_subset: assert property (
    watchdog_tick_scaled |-> watchdog_tick)
    else $error("scaled tick without source tick");
  a_sleep_irq_hold: assert property (
    $past(sleep_mode) && $past(sleep_mode, 2) && !$past(avs_write)
    && !$past(avs_write, 2) |-> $stable(timer_irq))
    else $error("interrupt changed during sleep");
  a_irq_fall_write: assert property ($fell(timer_irq) |->
    $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("interrupt dropped without software write");
  a_dir_write: assert property ($changed(port_a_direction) |->
    $past(avs_write) || $past(avs_write, 2))
    else $error("direction changed without write");
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(timer_irq));
  cover property (watchdog_tick_scaled);
endmodule

bind tsp_timer tsp_timer_properties chk_i (.mclk, .rst_n, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .sleep_mode, .watchdog_tick,
  .watchdog_tick_scaled, .timer_irq, .port_a_direction);

// File: testbench.sv
// self-checking bench for the timer/counter block
`timescale 1ns/1ps
module testbench;
  // ----
  // signals
  // ----
  logic        mclk;
  logic        rst_n = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         counter_input_pin;
  logic        sleep_mode = 1'b0;
  logic        watchdog_tick = 1'b0;
  logic        watchdog_clear_instruction = 1'b0;
  wire         watchdog_tick_scaled;
  wire         timer_irq;
  wire  [4:0]  port_a_direction;
  logic [31:0] a;
  logic [31:0] b;
  int          error_cnt = 0;
  int          total_checks = 0;
  localparam logic [9:0] A_CNT = 10'h004;
  localparam logic [9:0] A_INT = 10'h02C;
  localparam logic [9:0] A_CFG = 10'h204;
  localparam logic [9:0] A_DIR = 10'h214;

  tsp_timer uut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .counter_input_pin, .sleep_mode, .watchdog_tick,
    .watchdog_clear_instruction, .watchdog_tick_scaled, .timer_irq,
    .port_a_direction);
  tsp_pin_src src (.mclk(mclk), .pin(counter_input_pin));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ----
  // tasks
  // ----
  task automatic wr(input logic [9:0] ad, input logic [7:0] d,
                    input logic [3:0] be = 4'h1);
    @(posedge mclk);
    avs_address    <= ad;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] ad, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= ad;
    avs_read    <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [9:0] ad, input logic [31:0] e);
    rd(ad, a);
    chk(a, e);
  endtask
  task automatic wdt_clear;
    @(posedge mclk) watchdog_clear_instruction <= 1'b1;
    @(posedge mclk) watchdog_clear_instruction <= 1'b0;
  endtask
  task automatic to_wdt;
    wdt_clear();
    wr(A_CNT, 8'h00);
    wr(A_CFG, 8'h2F);
    wdt_clear();
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    int n;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rc(A_CFG, 32'hFF);
    rc(A_CNT, 32'h00);
    rc(A_INT, 32'h00);
    rc(10'h3FC, 32'h00);
    wr(A_DIR, 8'h0A, 4'h0);
    rc(A_DIR, 32'h1F);
    wr(A_DIR, 8'h0A);
    rc(A_DIR, 32'h0A);
    chk(port_a_direction, 32'h0A);
    done("registers");
    wr(A_CFG, 8'h08);
    wr(A_CNT, 8'hF0);
    rc(A_CNT, 32'hF0);
    repeat (100) @(posedge mclk);
    rc(A_INT, 32'h04);
    chk(timer_irq, 1'b0);
    wr(A_INT, 8'h24);
    repeat (3) @(posedge mclk);
    chk(timer_irq, 1'b1);
    repeat (20) @(posedge mclk);
    chk(timer_irq, 1'b1);
    wr(A_INT, 8'h20);
    repeat (3) @(posedge mclk);
    chk(timer_irq, 1'b0);
    rc(A_INT, 32'h20);
    rd(A_CNT, a);
    repeat (37) @(posedge mclk);
    rd(A_CNT, b);
    chk(8'(b - a), 8'd10);
    sleep_mode <= 1'b1;
    rd(A_CNT, a);
    repeat (37) @(posedge mclk);
    rd(A_CNT, b);
    chk(b, a);
    sleep_mode <= 1'b0;
    done("timer");
    wdt_clear();
    for (int r = 0; r < 8; r++) begin
      wr(A_CFG, 8'(r));
      wr(A_CNT, 8'h00);
      repeat (8 << r) @(posedge mclk);
      rd(A_CNT, a);
      repeat ((16 << r) - 3) @(posedge mclk);
      rd(A_CNT, b);
      chk(8'(b - a), 8'd2);
    end
    done("prescaler");
    to_wdt();
    for (int e = 0; e < 2; e++) begin
      wr(A_CFG, e ? 8'h38 : 8'h28);
      wr(A_CNT, 8'h00);
      repeat (12) @(posedge mclk);
      src.level(1'b1);
      repeat (20) @(posedge mclk);
      rc(A_CNT, e ? 32'h0 : 32'h1);
      src.level(1'b0);
      repeat (20) @(posedge mclk);
      rc(A_CNT, 32'h1);
    end
    wdt_clear();
    wr(A_CFG, 8'h20);
    wr(A_CNT, 8'h00);
    repeat (12) @(posedge mclk);
    src.pulses(6, 2, 2);
    repeat (20) @(posedge mclk);
    rc(A_CNT, 32'h3);
    done("counter");
    to_wdt();
    for (int i = 0; i < 4; i++) begin
      if (i == 3) wdt_clear();
      wr(A_CFG, (i == 3) ? 8'h00 : 8'(8 + i));
      wdt_clear();
      n = 0;
      repeat (8) begin
        @(posedge mclk) watchdog_tick <= 1'b1;
        @(posedge mclk) watchdog_tick <= 1'b0;
        if (watchdog_tick_scaled === 1'b1) n++;
        repeat (2) @(posedge mclk);
      end
      chk(n, (i == 3) ? 8 : (8 >> i));
    end
    done("watchdog");
    stop_test();
  end

  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule
